/* src/ltic_pkg.sv */
// Summary of operation
// - Driver-on input high enables the transmitter
// - Driver-on input rules outputs in both modes
// - Transmitter off tri-states tip and ring
// - Edge from pin (hardware) or bit (host)
// - Hardware mode, pin high: rising-edge sampling
// - Host mode: edge pin is serial clock
// - Positive rail sampled in every format
// - Dual-rail: negative rail sampled too
// - Single-rail: negative rail ignored, tied low
package ltic_pkg;

	// Reset values of the link-side state
	localparam logic       LINE_DATA_RST  = 1'b0;
	localparam logic       LINE_OE_RST    = 1'b0;
	localparam logic       SAMPLE_RST     = 1'b0;
	localparam logic [1:0] SYNC_RST       = 2'b00;
	localparam logic [1:0] LINK_RST_ASSERT = 2'b11;

	// Reset values of the reference-side status
	localparam logic       STATUS_RST     = 1'b0;
	localparam logic [2:0] MARK_SYNC_RST  = 3'b000;

	// Edge choice: rising when high, falling when low
	localparam logic       EDGE_RISING    = 1'b1;

endpackage : ltic_pkg

/* src/ltic_line_tx_input_capture.sv */
`timescale 1ns/1ns
module ltic_line_tx_input_capture (
	input  wire logic ref_clk,               // Reference clock, 25 MHz
	input  wire logic rst,                   // Asynchronous reset, active high
	input  wire logic host_mode,             // Host mode select, ref_clk domain
	input  wire logic host_edge_rise_bit,    // Channel control bit: rising edge when high
	input  wire logic dual_rail_mode,        // Dual-rail input format when high
	input  wire logic tx_line_clock,         // Transmit clock from the framer
	input  wire logic line_driver_on,        // Transmitter on pin, async
	input  wire logic tx_sample_edge_select, // Edge select pin, serial clock in host mode
	input  wire logic tx_positive_rail,      // Positive data rail, tx_line_clock domain
	input  wire logic tx_negative_rail,      // Negative data rail, tx_line_clock domain
	output logic      line_out_tip,          // Tip line data
	output logic      line_out_tip_oe,       // Tip output enable, high while driven
	output logic      line_out_ring,         // Ring line data
	output logic      line_out_ring_oe,      // Ring output enable, high while driven
	output logic      driver_on_status,      // Driver enabled, seen in ref_clk domain
	output logic      mark_seen_pulse        // One-cycle pulse per positive mark sent
);

	////////////////////////////////////////////////////////////////////////////
	// Link-domain reset: asserted at once, released on a link clock edge

	logic [1:0] lnk_rst_sync_ff;
	logic       lnk_rst;

	// Release is synchronous so the capture flops leave reset cleanly
	always_ff @(posedge tx_line_clock or posedge rst) begin
		if (rst) begin
			lnk_rst_sync_ff <= ltic_pkg::LINK_RST_ASSERT;
		end else begin
			lnk_rst_sync_ff <= {lnk_rst_sync_ff[0], 1'b0};
		end
	end
	assign lnk_rst = lnk_rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers into the link domain

	logic [1:0] drv_sync_ff;
	logic [1:0] edge_pin_sync_ff;
	logic [1:0] host_sync_ff;
	logic [1:0] host_bit_sync_ff;
	logic [1:0] dual_sync_ff;
	logic       drv_on;
	logic       edge_pin;
	logic       host_s;
	logic       host_bit;
	logic       dual_s;

	// Pins and ref_clk config bits each pass two flops before use
	always_ff @(posedge tx_line_clock or posedge lnk_rst) begin
		if (lnk_rst) begin
			drv_sync_ff      <= ltic_pkg::SYNC_RST;
			edge_pin_sync_ff <= ltic_pkg::SYNC_RST;
			host_sync_ff     <= ltic_pkg::SYNC_RST;
			host_bit_sync_ff <= ltic_pkg::SYNC_RST;
			dual_sync_ff     <= ltic_pkg::SYNC_RST;
		end else begin
			drv_sync_ff      <= {drv_sync_ff[0], line_driver_on};
			edge_pin_sync_ff <= {edge_pin_sync_ff[0], tx_sample_edge_select};
			host_sync_ff     <= {host_sync_ff[0], host_mode};
			host_bit_sync_ff <= {host_bit_sync_ff[0], host_edge_rise_bit};
			dual_sync_ff     <= {dual_sync_ff[0], dual_rail_mode};
		end
	end
	assign drv_on   = drv_sync_ff[1];
	assign edge_pin = edge_pin_sync_ff[1];
	assign host_s   = host_sync_ff[1];
	assign host_bit = host_bit_sync_ff[1];
	assign dual_s   = dual_sync_ff[1];

	////////////////////////////////////////////////////////////////////////////
	// Edge selection

	logic edge_rise;

	// In host mode the pin is the serial clock, so only the bit counts
	always_comb begin
		if (host_s) begin
			edge_rise = host_bit;
		end else begin
			edge_rise = (edge_pin == ltic_pkg::EDGE_RISING);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Rail capture on both edges

	logic rise_pos_ff;
	logic rise_neg_ff;
	logic fall_pos_ff;
	logic fall_neg_ff;

	// Rising-edge samples
	always_ff @(posedge tx_line_clock or posedge lnk_rst) begin
		if (lnk_rst) begin
			rise_pos_ff <= ltic_pkg::SAMPLE_RST;
			rise_neg_ff <= ltic_pkg::SAMPLE_RST;
		end else begin
			rise_pos_ff <= tx_positive_rail;
			rise_neg_ff <= tx_negative_rail;
		end
	end

	// Falling-edge samples; both kept so a mode change needs no restart
	always_ff @(negedge tx_line_clock or posedge lnk_rst) begin
		if (lnk_rst) begin
			fall_pos_ff <= ltic_pkg::SAMPLE_RST;
			fall_neg_ff <= ltic_pkg::SAMPLE_RST;
		end else begin
			fall_pos_ff <= tx_positive_rail;
			fall_neg_ff <= tx_negative_rail;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Rail choice and line drive

	logic nxt_pos;
	logic nxt_neg;
	logic tip_ff;
	logic ring_ff;
	logic oe_ff;
	logic mark_tgl_ff;

	localparam logic LTIC_NEG_NONE = 1'b0; // Single-rail: negative rail is ignored

	// Positive rail always used; negative only in dual-rail format
	always_comb begin
		nxt_pos = edge_rise ? rise_pos_ff : fall_pos_ff;
		nxt_neg = LTIC_NEG_NONE;
		if (dual_s) begin
			nxt_neg = edge_rise ? rise_neg_ff : fall_neg_ff;
		end
	end

	// Off means both outputs released and data parked low
	always_ff @(posedge tx_line_clock or posedge lnk_rst) begin
		if (lnk_rst) begin
			tip_ff  <= ltic_pkg::LINE_DATA_RST;
			ring_ff <= ltic_pkg::LINE_DATA_RST;
			oe_ff   <= ltic_pkg::LINE_OE_RST;
		end else begin
			oe_ff   <= drv_on;
			tip_ff  <= drv_on ? nxt_pos : ltic_pkg::LINE_DATA_RST;
			ring_ff <= drv_on ? nxt_neg : ltic_pkg::LINE_DATA_RST;
		end
	end

	// Toggle per mark sent, so one event crosses as one level change
	always_ff @(posedge tx_line_clock or posedge lnk_rst) begin
		if (lnk_rst) begin
			mark_tgl_ff <= ltic_pkg::SAMPLE_RST;
		end else if (drv_on && nxt_pos) begin
			mark_tgl_ff <= ~mark_tgl_ff;
		end
	end

	assign line_out_tip     = tip_ff;
	assign line_out_ring    = ring_ff;
	assign line_out_tip_oe  = oe_ff;
	assign line_out_ring_oe = oe_ff;

	////////////////////////////////////////////////////////////////////////////
	// Status back into the ref_clk domain

	logic [1:0] stat_sync_ff;
	logic [2:0] mark_sync_ff;
	logic       pulse_ff;

	// Limitation: toggles are only all seen with link clock under a third of ref_clk
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_sync_ff <= ltic_pkg::SYNC_RST;
			mark_sync_ff <= ltic_pkg::MARK_SYNC_RST;
			pulse_ff     <= ltic_pkg::STATUS_RST;
		end else begin
			stat_sync_ff <= {stat_sync_ff[0], oe_ff};
			mark_sync_ff <= {mark_sync_ff[1:0], mark_tgl_ff};
			pulse_ff     <= mark_sync_ff[2] ^ mark_sync_ff[1];
		end
	end
	assign driver_on_status = stat_sync_ff[1];
	assign mark_seen_pulse  = pulse_ff;

	////////////////////////////////////////////////////////////////////////////
	// Assertions, link domain

	sequence s_driver_raised;
		$rose(drv_on);
	endsequence

	sequence s_outputs_driven;
		line_out_tip_oe && line_out_ring_oe;
	endsequence

	// Pin steps held long enough to pass both synchroniser flops
	sequence s_pin_held_on;
		$rose(line_driver_on) ##1 line_driver_on [*2];
	endsequence

	sequence s_pin_held_off;
		$fell(line_driver_on) ##1 !line_driver_on [*2];
	endsequence

	sequence s_tip_from_rise;
		line_out_tip == $past(rise_pos_ff);
	endsequence

	sequence s_tip_from_fall;
		line_out_tip == $past(fall_pos_ff);
	endsequence

	sequence s_ring_from_rise;
		line_out_ring == $past(rise_neg_ff);
	endsequence

	sequence s_ring_from_fall;
		line_out_ring == $past(fall_neg_ff);
	endsequence

	a_driver_turn_on: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		s_driver_raised |=> s_outputs_driven)
		else $error("line outputs not enabled after driver on");

	a_oe_follows_pin: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		##1 (line_out_tip_oe == $past(drv_on)) && (line_out_ring_oe == line_out_tip_oe))
		else $error("output enable not following driver pin");

	a_off_tristate: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		!drv_on |=> !line_out_tip_oe && !line_out_ring_oe && !line_out_tip && !line_out_ring)
		else $error("line outputs driven while transmitter off");

	// Judged on the line data, so a wrong edge choice shows up
	a_hw_rise_edge: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		!host_s && edge_pin && drv_on |=> s_tip_from_rise)
		else $error("hardware high edge pin not rising");

	// Falling samples are half a cycle old at the output edge
	a_hw_fall_edge: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		!host_s && !edge_pin && drv_on |=> s_tip_from_fall)
		else $error("hardware low edge pin not falling");

	// Host mode edge comes from the control bit alone
	a_host_edge_bit: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		host_s && drv_on |=> line_out_tip == ($past(host_bit) ? $past(rise_pos_ff) : $past(fall_pos_ff)))
		else $error("host mode edge not from control bit");

	// Mode entry may move the edge; only steady host mode is judged
	a_host_pin_ignored: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		host_s && $past(host_s) && $stable(host_bit) && $changed(edge_pin) |-> $stable(edge_rise))
		else $error("serial clock pin disturbed edge choice in host mode");

	a_pos_rail_used: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		drv_on |=> line_out_tip == ($past(edge_rise) ? $past(rise_pos_ff) : $past(fall_pos_ff)))
		else $error("tip not the sampled positive rail");

	a_neg_rail_dual: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		drv_on && dual_s |=> line_out_ring == ($past(edge_rise) ? $past(rise_neg_ff) : $past(fall_neg_ff)))
		else $error("ring not the sampled negative rail");

	a_single_rail_neg: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		!dual_s |=> !line_out_ring)
		else $error("negative rail used in single-rail format");

	// Enable follows a steady pin rise after two sync flops and the output flop
	a_on_three_edges: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		s_pin_held_on |=> s_outputs_driven)
		else $error("line outputs not enabled three edges after pin rise");

	// Release follows a steady pin fall just as late
	a_off_three_edges: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		s_pin_held_off |=> !line_out_tip_oe && !line_out_ring_oe)
		else $error("line outputs not released three edges after pin fall");

	// Ring pairs with tip on the same selected edge
	a_hw_ring_rise: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		!host_s && edge_pin && drv_on && dual_s |=> s_ring_from_rise)
		else $error("ring not the rising negative sample");

	// Falling choice for ring as well
	a_hw_ring_fall: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		!host_s && !edge_pin && drv_on && dual_s |=> s_ring_from_fall)
		else $error("ring not the falling negative sample");

	// The toggle moves exactly when a one is loaded onto tip
	a_mark_per_tip: assert property (@(posedge tx_line_clock) disable iff (lnk_rst)
		$changed(mark_tgl_ff) == line_out_tip)
		else $error("mark toggle out of step with tip");

	////////////////////////////////////////////////////////////////////////////
	// Assertions, reference domain

	// Status lags the enable by exactly the two synchroniser flops
	a_status_follows: assert property (@(posedge ref_clk) disable iff (rst)
		driver_on_status == $past(oe_ff, 2))
		else $error("driver status not two cycles behind enable");

	// One pulse per toggle: two sync flops, the detector flop, then the pulse flop
	a_pulse_per_mark: assert property (@(posedge ref_clk) disable iff (rst)
		mark_seen_pulse == ($past(mark_tgl_ff, 3) ^ $past(mark_tgl_ff, 4)))
		else $error("mark pulse not matching link toggle");

endmodule : ltic_line_tx_input_capture

/* testbench/ltic_framer_model.sv */
`timescale 1ns/1ns
module ltic_framer_model (
	input  wire logic tx_line_clock, // Transmit clock
	input  wire logic sample_rise,   // Device samples on rising edge when high
	input  wire logic dual_rail,     // Dual-rail format
	input  wire logic run,           // Pattern when high, zeros when low
	input  wire logic noisy_neg,     // Drive the negative rail even in single-rail
	output logic      pos_rail,      // Positive rail
	output logic      neg_rail,      // Negative rail
	output logic      exp_pos,       // Positive bit launched one bit earlier
	output logic      exp_neg        // Negative bit launched one bit earlier
);
	logic [7:0] lfsr_ff = 8'h5a; // Any non-zero start state

	////////////////////////////////
	// Launch on the opposite edge so each bit is settled half a cycle at the sampling edge
	always @(tx_line_clock) begin
		if (tx_line_clock !== sample_rise) begin
			exp_pos  <= pos_rail;
			exp_neg  <= neg_rail;
			pos_rail <= run & lfsr_ff[0];
			neg_rail <= run & (dual_rail | noisy_neg) & lfsr_ff[3];
			lfsr_ff  <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
		end
	end
endmodule : ltic_framer_model

/* testbench/ltic_line_tx_input_capture_tb.sv */
`timescale 1ns/1ns
module ltic_line_tx_input_capture_tb;
	logic ref_clk = 1'b0, tx_line_clock = 1'b0, rst = 1'b1, host_mode = 1'b0, host_edge_rise_bit = 1'b0;
	logic dual_rail_mode = 1'b1, line_driver_on = 1'b1, tx_sample_edge_select = 1'b1, run = 1'b0;
	logic noisy = 1'b0, sample_rise = 1'b1, tx_positive_rail, tx_negative_rail, exp_pos, exp_neg;
	logic line_out_tip, line_out_tip_oe, line_out_ring, line_out_ring_oe, driver_on_status, mark_seen_pulse;
	int   miscompares = 0, num_checks = 0, tip_ones = 0, pulses = 0;

	////////////////////////////////
	// Unrelated clocks: 40 ns reference, 125 ns link
	always #20 ref_clk = ~ref_clk;
	always begin
		#62 tx_line_clock = ~tx_line_clock;
		#63 tx_line_clock = ~tx_line_clock;
	end

	ltic_line_tx_input_capture dut_u (.ref_clk, .rst, .host_mode, .host_edge_rise_bit, .dual_rail_mode,
		.tx_line_clock, .line_driver_on, .tx_sample_edge_select, .tx_positive_rail, .tx_negative_rail,
		.line_out_tip, .line_out_tip_oe, .line_out_ring, .line_out_ring_oe, .driver_on_status, .mark_seen_pulse);
	ltic_framer_model framer_u (.tx_line_clock, .sample_rise, .dual_rail(dual_rail_mode), .run, .noisy_neg(noisy),
		.pos_rail(tx_positive_rail), .neg_rail(tx_negative_rail), .exp_pos, .exp_neg);

	// Marks on the line against pulses on the status side
	always @(negedge ref_clk) if (mark_seen_pulse === 1'b1) pulses++;
	always @(posedge tx_line_clock) begin
		#30 if (line_out_tip === 1'b1) tip_ones++;
	end

	////////////////////////////////
	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_bit

	task automatic check_cnt(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_cnt

	// In host mode the pin opposes the bit, so a design that reads it fails
	task automatic set_cfg(input logic hm, input logic sel, input logic dual);
		@(posedge ref_clk);
		host_mode <= hm;
		host_edge_rise_bit <= sel;
		tx_sample_edge_select <= hm ? ~sel : sel;
		dual_rail_mode <= dual;
		noisy <= ~dual;
		sample_rise <= sel;
	endtask : set_cfg

	task automatic check_line(input int n, input logic on);
		repeat (n) begin
			@(posedge tx_line_clock);
			#30;
			check_bit(line_out_tip, on & exp_pos);
			check_bit(line_out_ring, on & dual_rail_mode & exp_neg);
			check_bit(line_out_tip_oe, on);
			check_bit(line_out_ring_oe, on);
		end
	endtask : check_line

	task automatic test_edges();
		for (int i = 0; i < 8; i++) begin
			set_cfg(i[2], i[1], i[0]);
			repeat (6) @(posedge tx_line_clock);
			check_line(12, 1'b1);
		end
	endtask : test_edges

	// Pin toggles as a serial clock in host mode; the line must not notice
	task automatic test_serial_clock();
		set_cfg(1'b1, 1'b0, 1'b1);
		repeat (6) @(posedge tx_line_clock);
		fork
			repeat (40) begin
				@(posedge ref_clk);
				tx_sample_edge_select <= ~tx_sample_edge_select;
			end
			check_line(12, 1'b1);
		join
	endtask : test_serial_clock

	// Enable follows the pin after exactly three link edges
	task automatic test_driver(input logic on);
		@(posedge ref_clk);
		line_driver_on <= on;
		repeat (2) @(posedge tx_line_clock);
		#30;
		check_bit(line_out_tip_oe, ~on);
		check_line(4, on);
		repeat (3) @(posedge ref_clk);
		#1;
		check_bit(driver_on_status, on);
	endtask : test_driver

	task automatic test_marks();
		@(posedge ref_clk);
		run <= 1'b0;
		repeat (8) @(posedge tx_line_clock);
		tip_ones = 0;
		pulses = 0;
		@(posedge ref_clk);
		run <= 1'b1;
		repeat (24) @(posedge tx_line_clock);
		@(posedge ref_clk);
		run <= 1'b0;
		repeat (8) @(posedge tx_line_clock);
		check_cnt(pulses, tip_ones);
		check_cnt(int'(tip_ones > 3), 1);
	endtask : test_marks

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	////////////////////////////////
	// Reset spans several link edges so the link side sees it
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge tx_line_clock);
		@(posedge ref_clk);
		run <= 1'b1;
		test_edges();
		test_serial_clock();
		for (int m = 0; m < 2; m++) begin
			set_cfg(m[0], 1'b1, 1'b1);
			test_driver(1'b0);
			test_driver(1'b1);
		end
		test_marks();
		report_and_stop();
	end

	// Watchdog well beyond the expected run of some 30 us
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule : ltic_line_tx_input_capture_tb
